// >>> design/adc_ctrl_pkg.sv
// Constants and types shared by the converter control block and its pacer.
// Assumes a 10 MHz system clock and a 20 MHz conversion time base.
package adc_ctrl_pkg;

  // Register addresses.
  localparam logic [31:0] OFS_INPUT_BUFFER_CONTROL = 32'h40081400;
  localparam logic [31:0] OFS_SEQUENCER_CONTROL = 32'h40086088;
  localparam logic [31:0] OFS_SEQUENCER_CONFIGURATION = 32'h4008608C;
  localparam logic [31:0] OFS_DIGITAL_THRESHOLD_CONFIG = 32'h40086098;
  localparam logic [31:0] OFS_CONVERSION_TIMING_CONFIG = 32'h4008609C;
  localparam logic [31:0] OFS_TEMPERATURE_SENSOR_CONFIG = 32'h40087830;
  localparam logic [31:0] OFS_REFERENCE_CONFIG = 32'h40087834;
  localparam logic [19:0] NARROW_SPACE_PAGE = 20'h40081;

  // Values after reset.
  localparam logic [15:0] RST_INPUT_BUFFER_CONTROL = 16'h000F;
  localparam logic [28:0] RST_SEQUENCER_MASK = 29'h00000000;
  localparam logic [27:0] RST_SEQUENCER_CONFIGURATION = 28'h008C631;
  localparam logic [17:0] RST_DIGITAL_THRESHOLD_CONFIG = 18'h00000;
  localparam logic [31:0] RST_CONVERSION_TIMING_CONFIG = 32'h000A00C8;
  localparam logic [1:0] RST_TEMPERATURE_SENSOR_CONFIG = 2'h0;
  localparam logic [3:0] RST_REFERENCE_CONFIG = 4'h0;

  // Field positions.
  localparam int SEQ_RESTART_BIT = 31;
  localparam int SEQ_ENABLE_BIT = 30;
  localparam int SEQ_MASK_W = 29;
  localparam int SEQ_DELAY_LSB = 20;
  localparam int NEG_SEL_W = 5;
  localparam int NEG0_LSB = 0;
  localparam int NEG2_LSB = 5;
  localparam int NEG4_LSB = 10;
  localparam int NEG6_LSB = 15;
  localparam int CMP_LEVEL_LSB = 2;
  localparam int CMP_DIR_BIT = 1;
  localparam int CMP_EN_BIT = 0;
  localparam int CMP_FLAG_BIT = 18;
  localparam int ACQ_COUNT_LSB = 16;
  localparam int CONV_DIV_LSB = 0;
  localparam int CNT_W = 10;

  // Special codes.
  localparam logic [7:0] DELAY_HALT = 8'hFF;
  localparam logic [4:0] NEG_SINGLE_ENDED = 5'h11;
  localparam logic [31:0] AUTO_TIMING_VALUE = 32'h007D00FA;
  localparam logic [4:0] CH_TEMP_SENSOR = 5'h16;
  localparam logic [4:0] CH_IOVDD_HALF = 5'h19;
  localparam logic [4:0] CH_AVDD_HALF = 5'h1A;
  localparam logic [4:0] CMP_CHANNEL = 5'h04;
  localparam logic [5:0] NO_CHANNEL = 6'h3F;

  // Timing.
  localparam int SYS_CLK_HZ = 10000000;
  localparam int BASE_CLK_HZ = 20000000;
  localparam logic [10:0] BASE_TICKS_PER_CYCLE = 11'(BASE_CLK_HZ / SYS_CLK_HZ);
  localparam int SYS_PERIOD_PS = 100000;
  localparam int ACCESS_WIDE_PS = 100000;
  localparam int ACCESS_NARROW_PS = 62500;
  localparam logic [3:0] ACCESS_WIDE_CYC =
    4'((ACCESS_WIDE_PS + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS);
  localparam logic [3:0] ACCESS_NARROW_CYC =
    4'((ACCESS_NARROW_PS + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS);

  typedef enum logic [1:0] {
    S_IDLE,
    S_RUN,
    S_GAP,
    S_SINGLE
  } seq_state_t;

endpackage : adc_ctrl_pkg

// >>> design/adc_sequencer_control.sv
// Converter control: registers, sequencer, digital comparator and timing.
// Assumes link, single request and converter result share the 10 MHz clock.
//
// Contract
// - Writing one to restart returns the sequence to its first included channel.
// - Writing one to the enable bit starts the channel sequencer; the code starts it only from idle with a nonzero mask from an earlier write.
// - A 29-bit mask includes a channel when set, skips it when clear.
// - Mask bit n belongs to channel code n.
// - An 8-bit delay inserts 0 to 254 units between passes.
// - Delay 255 halts after one pass; software re-enables for another pass.
// - Channels 0, 2, 4, 6 have 5-bit negative inputs; 0x11 means single-ended.
// - A 16-bit threshold is compared against every channel 4 result.
// - Direction clear trips on threshold below data, set on threshold above.
// - The comparator works only while its enable bit is one.
// - Acquisition lasts the 10-bit count over 20 MHz; reset count gives 500 ns.
// - Conversion rate is 20 MHz over a 10-bit divider, reset 0xC8.
// - Single conversion on codes 22, 25, 26 loads 0x7D00FA into timing.
// - While sequencing, timing keeps its value and the rate stays unchanged.
// - Link access takes 8 cycles wide, 5 cycles narrow at 80 MHz; at the 10 MHz clock here both take 1 cycle.
// - Input buffer power field powers down N, P, both or neither.
// - Input buffer skip field bypasses none, N, P or both sides.
// - Sensor power bit zero keeps it powered, one powers it down.
// - Codes 0x16, 0x19, 0x1A route sensor, half I/O, half analog supply.
`timescale 1ns/100ps
`default_nettype none
module adc_sequencer_control
  import adc_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // Register link
  input wire logic REG_REQ,
  input wire logic REG_WRITE,
  input wire logic [31:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  output logic REG_ACK,
  output logic [31:0] REG_RDATA,
  // Single conversion request
  input wire logic SINGLE_REQ,
  input wire logic [4:0] SINGLE_CH,
  // Converter
  output logic CONV_START,
  output logic [4:0] CONV_CH,
  output logic [4:0] CONV_NEG,
  output logic ACQ_ACTIVE,
  input wire logic RESULT_VALID,
  input wire logic [15:0] RESULT_DATA,
  // Internal source routing
  output logic ROUTE_TEMP,
  output logic ROUTE_IOVDD_HALF,
  output logic ROUTE_AVDD_HALF,
  // Analog configuration
  output logic [1:0] INBUF_POWER_OFF,
  output logic [1:0] INBUF_SKIP,
  output logic TEMP_POWER_OFF,
  output logic TEMP_MODULATION,
  output logic [3:0] REF_CTRL,
  // Status
  output logic SEQ_BUSY,
  output logic CMP_TRIP
);

  typedef struct packed {
    logic acc_busy;
    logic [3:0] acc_cnt;
    logic acc_wr;
    logic [31:0] acc_addr;
    logic [31:0] acc_wdata;
    logic ack;
    logic [31:0] rdata;
    logic [15:0] input_buffer_control;
    logic [28:0] seq_mask;
    logic [27:0] seq_cfg;
    logic [17:0] cmp_cfg;
    logic cmp_flag;
    logic [31:0] timing_cfg;
    logic [1:0] temp_cfg;
    logic [3:0] ref_cfg;
    seq_state_t st;
    logic [5:0] next_idx;
    logic [7:0] delay_cnt;
    logic [4:0] single_ch;
    logic conv_start;
    logic [4:0] conv_ch;
    logic [4:0] conv_neg;
    logic route_temp;
    logic route_iovdd;
    logic route_avdd;
  } ctrl_state_t;

  localparam ctrl_state_t CTRL_RESET = '{
    acc_busy: 1'b0, acc_cnt: 4'h0, acc_wr: 1'b0, acc_addr: 32'h00000000,
    acc_wdata: 32'h00000000, ack: 1'b0, rdata: 32'h00000000,
    input_buffer_control: RST_INPUT_BUFFER_CONTROL, seq_mask: RST_SEQUENCER_MASK,
    seq_cfg: RST_SEQUENCER_CONFIGURATION, cmp_cfg: RST_DIGITAL_THRESHOLD_CONFIG,
    cmp_flag: 1'b0, timing_cfg: RST_CONVERSION_TIMING_CONFIG,
    temp_cfg: RST_TEMPERATURE_SENSOR_CONFIG, ref_cfg: RST_REFERENCE_CONFIG,
    st: S_IDLE, next_idx: 6'h00, delay_cnt: 8'h00, single_ch: 5'h00,
    conv_start: 1'b0, conv_ch: 5'h00, conv_neg: NEG_SINGLE_ENDED,
    route_temp: 1'b0, route_iovdd: 1'b0, route_avdd: 1'b0};

  ctrl_state_t s_reg;
  ctrl_state_t s_next;

  pacer_if pif ();

  conversion_pacer u_pacer (
    .CLK_SYS(CLK_SYS),
    .RST_N(RST_N),
    .p(pif.pacer)
  );

  // Lowest included channel at or above the start position.
  function automatic logic [5:0] next_ch(input logic [28:0] mask, input logic [5:0] from);
    logic [5:0] res;
    res = NO_CHANNEL;
    for (int i = SEQ_MASK_W - 1; i >= 0; i--) begin
      if (mask[i] && (6'(i) >= from)) begin
        res = 6'(i);
      end
    end
    return res;
  endfunction : next_ch

  function automatic logic [4:0] neg_for(input logic [5:0] ch, input logic [27:0] cfg);
    logic [4:0] neg;
    neg = NEG_SINGLE_ENDED;
    if (ch == 6'h00) begin
      neg = cfg[NEG0_LSB +: NEG_SEL_W];
    end else if (ch == 6'h02) begin
      neg = cfg[NEG2_LSB +: NEG_SEL_W];
    end else if (ch == 6'h04) begin
      neg = cfg[NEG4_LSB +: NEG_SEL_W];
    end else if (ch == 6'h06) begin
      neg = cfg[NEG6_LSB +: NEG_SEL_W];
    end
    return neg;
  endfunction : neg_for

  function automatic logic auto_timing_ch(input logic [4:0] ch);
    return (ch == CH_TEMP_SENSOR) || (ch == CH_IOVDD_HALF) || (ch == CH_AVDD_HALF);
  endfunction : auto_timing_ch

  always_comb begin
    logic restart;
    logic enable;
    logic [5:0] pick;
    logic [5:0] after;
    logic [7:0] delay;
    logic [15:0] level;
    logic trip;
    logic [31:0] a;
    logic [31:0] w;
    restart = 1'b0;
    enable = 1'b0;
    pick = NO_CHANNEL;
    after = NO_CHANNEL;
    delay = s_reg.seq_cfg[SEQ_DELAY_LSB +: 8];
    level = s_reg.cmp_cfg[CMP_LEVEL_LSB +: 16];
    trip = 1'b0;
    a = s_reg.acc_addr;
    w = s_reg.acc_wdata;
    s_next = s_reg;
    s_next.ack = 1'b0;
    s_next.conv_start = 1'b0;

    // Register link: the access completes after its latency, then acknowledges.
    if (s_reg.acc_busy) begin
      if (s_reg.acc_cnt > 4'h1) begin
        s_next.acc_cnt = s_reg.acc_cnt - 4'h1;
      end else begin
        s_next.acc_busy = 1'b0;
        s_next.ack = 1'b1;
        s_next.rdata = 32'h00000000;
        if (a == OFS_INPUT_BUFFER_CONTROL) begin
          if (s_reg.acc_wr) begin
            s_next.input_buffer_control = w[15:0];
          end else begin
            s_next.rdata = {16'h0000, s_reg.input_buffer_control};
          end
        end else if (a == OFS_SEQUENCER_CONTROL) begin
          if (s_reg.acc_wr) begin
            s_next.seq_mask = w[SEQ_MASK_W-1:0];
            restart = w[SEQ_RESTART_BIT];
            enable = w[SEQ_ENABLE_BIT];
          end else begin
            s_next.rdata = {3'h0, s_reg.seq_mask};
          end
        end else if (a == OFS_SEQUENCER_CONFIGURATION) begin
          if (s_reg.acc_wr) begin
            s_next.seq_cfg = w[27:0];
          end else begin
            s_next.rdata = {4'h0, s_reg.seq_cfg};
          end
        end else if (a == OFS_DIGITAL_THRESHOLD_CONFIG) begin
          if (s_reg.acc_wr) begin
            s_next.cmp_cfg = w[17:0];
            if (w[CMP_FLAG_BIT]) begin
              s_next.cmp_flag = 1'b0;
            end
          end else begin
            s_next.rdata = {13'h0000, s_reg.cmp_flag, s_reg.cmp_cfg};
          end
        end else if (a == OFS_CONVERSION_TIMING_CONFIG) begin
          if (s_reg.acc_wr) begin
            s_next.timing_cfg = w;
          end else begin
            s_next.rdata = s_reg.timing_cfg;
          end
        end else if (a == OFS_TEMPERATURE_SENSOR_CONFIG) begin
          if (s_reg.acc_wr) begin
            s_next.temp_cfg = w[1:0];
          end else begin
            s_next.rdata = {30'h00000000, s_reg.temp_cfg};
          end
        end else if (a == OFS_REFERENCE_CONFIG) begin
          if (s_reg.acc_wr) begin
            s_next.ref_cfg = w[3:0];
          end else begin
            s_next.rdata = {28'h0000000, s_reg.ref_cfg};
          end
        end
      end
    end else if (REG_REQ && !s_reg.ack) begin
      s_next.acc_busy = 1'b1;
      s_next.acc_wr = REG_WRITE;
      s_next.acc_addr = REG_ADDR;
      s_next.acc_wdata = REG_WDATA;
      // Narrow registers sit on the faster page of the link.
      s_next.acc_cnt = (REG_ADDR[31:12] == NARROW_SPACE_PAGE) ?
                       ACCESS_NARROW_CYC : ACCESS_WIDE_CYC;
    end

    // Channel sequencer.
    case (s_reg.st)
      S_IDLE: begin
        if (enable && (s_reg.seq_mask != 29'h00000000)) begin
          s_next.st = S_RUN;
          s_next.next_idx = 6'h00;
        end else if (SINGLE_REQ) begin
          s_next.st = S_SINGLE;
          s_next.single_ch = SINGLE_CH;
          if (auto_timing_ch(SINGLE_CH)) begin
            s_next.timing_cfg = AUTO_TIMING_VALUE;
          end
        end
      end
      S_RUN: begin
        if (pif.tick) begin
          pick = next_ch(s_reg.seq_mask, s_reg.next_idx);
          if (pick == NO_CHANNEL) begin
            pick = next_ch(s_reg.seq_mask, 6'h00);
          end
          if (pick == NO_CHANNEL) begin
            s_next.st = S_IDLE;
          end else begin
            s_next.conv_start = 1'b1;
            s_next.conv_ch = pick[4:0];
            s_next.conv_neg = neg_for(pick, s_reg.seq_cfg);
            after = next_ch(s_reg.seq_mask, pick + 6'h01);
            if (after != NO_CHANNEL) begin
              s_next.next_idx = pick + 6'h01;
            end else begin
              s_next.next_idx = 6'h00;
              if (delay == DELAY_HALT) begin
                s_next.st = S_IDLE;
              end else if (delay != 8'h00) begin
                s_next.st = S_GAP;
                s_next.delay_cnt = delay;
              end
            end
          end
        end
      end
      S_GAP: begin
        if (pif.tick) begin
          if (s_reg.delay_cnt <= 8'h01) begin
            s_next.st = S_RUN;
          end else begin
            s_next.delay_cnt = s_reg.delay_cnt - 8'h01;
          end
        end
      end
      S_SINGLE: begin
        if (pif.tick) begin
          s_next.conv_start = 1'b1;
          s_next.conv_ch = s_reg.single_ch;
          s_next.conv_neg = NEG_SINGLE_ENDED;
          s_next.st = S_IDLE;
        end
      end
      default: begin
        s_next.st = S_IDLE;
      end
    endcase

    // A restart during a pass or its gap aims the next period at the first channel.
    if (restart && ((s_reg.st == S_RUN) || (s_reg.st == S_GAP))) begin
      s_next.next_idx = 6'h00;
      s_next.st = S_RUN;
    end

    // The flag set follows the clear, so a trip in the clearing cycle is kept.
    if (RESULT_VALID && (s_reg.conv_ch == CMP_CHANNEL) && s_reg.cmp_cfg[CMP_EN_BIT]) begin
      trip = s_reg.cmp_cfg[CMP_DIR_BIT] ? (level > RESULT_DATA) : (level < RESULT_DATA);
      if (trip) begin
        s_next.cmp_flag = 1'b1;
      end
    end

    s_next.route_temp = (s_next.conv_ch == CH_TEMP_SENSOR);
    s_next.route_iovdd = (s_next.conv_ch == CH_IOVDD_HALF);
    s_next.route_avdd = (s_next.conv_ch == CH_AVDD_HALF);
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      s_reg <= CTRL_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // Timing comes only from the register; only link writes and single conversions on codes 22, 25, 26 alter it.
  assign pif.divider = s_reg.timing_cfg[CONV_DIV_LSB +: CNT_W];
  assign pif.acq_count = s_reg.timing_cfg[ACQ_COUNT_LSB +: CNT_W];
  assign pif.run = (s_reg.st != S_IDLE);
  assign pif.acq_go = s_reg.conv_start;

  assign REG_ACK = s_reg.ack;
  assign REG_RDATA = s_reg.rdata;
  assign CONV_START = s_reg.conv_start;
  assign CONV_CH = s_reg.conv_ch;
  assign CONV_NEG = s_reg.conv_neg;
  assign ACQ_ACTIVE = pif.acq_active;
  assign ROUTE_TEMP = s_reg.route_temp;
  assign ROUTE_IOVDD_HALF = s_reg.route_iovdd;
  assign ROUTE_AVDD_HALF = s_reg.route_avdd;
  assign INBUF_POWER_OFF = s_reg.input_buffer_control[3:2];
  assign INBUF_SKIP = s_reg.input_buffer_control[1:0];
  assign TEMP_POWER_OFF = s_reg.temp_cfg[0];
  assign TEMP_MODULATION = s_reg.temp_cfg[1];
  assign REF_CTRL = s_reg.ref_cfg;
  assign SEQ_BUSY = (s_reg.st != S_IDLE);
  assign CMP_TRIP = s_reg.cmp_flag;

endmodule : adc_sequencer_control
`default_nettype wire

// >>> design/conversion_pacer.sv
// Conversion period and acquisition window generator.
// Assumes a 10 MHz clock: two 20 MHz base ticks a cycle.
`timescale 1ns/100ps
`default_nettype none
module conversion_pacer
  import adc_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // Link to the control block
  pacer_if.pacer p
);

  typedef struct packed {
    logic [10:0] acc;
    logic tick;
    logic [10:0] acq_left;
    logic acq_active;
  } pacer_state_t;

  localparam pacer_state_t PACER_RESET = '{acc: 11'h000, tick: 1'b0,
                                           acq_left: 11'h000, acq_active: 1'b0};

  pacer_state_t s_reg;
  pacer_state_t s_next;

  always_comb begin
    logic [10:0] div_eff;
    logic [10:0] sum;
    div_eff = 11'h000;
    sum = 11'h000;
    s_next = s_reg;
    s_next.tick = 1'b0;
    // Dividers below two cannot tick faster than once a cycle, so they act as two.
    div_eff = (p.divider < 10'h002) ? 11'h002 : {1'b0, p.divider};
    if (p.run) begin
      sum = s_reg.acc + BASE_TICKS_PER_CYCLE;
      if (sum >= div_eff) begin
        s_next.tick = 1'b1;
        s_next.acc = sum - div_eff;
      end else begin
        s_next.acc = sum;
      end
    end else begin
      s_next.acc = 11'h000;
    end
    if (p.acq_go) begin
      s_next.acq_left = {1'b0, p.acq_count};
      s_next.acq_active = (p.acq_count != 10'h000);
    end else if (s_reg.acq_left > BASE_TICKS_PER_CYCLE) begin
      s_next.acq_left = s_reg.acq_left - BASE_TICKS_PER_CYCLE;
    end else begin
      s_next.acq_left = 11'h000;
      s_next.acq_active = 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      s_reg <= PACER_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign p.tick = s_reg.tick;
  assign p.acq_active = s_reg.acq_active;

endmodule : conversion_pacer
`default_nettype wire

// >>> design/pacer_if.sv
// Signals between the control block and its conversion pacer.
// Both ends sit on the same system clock.
`timescale 1ns/100ps
`default_nettype none
interface pacer_if;
  import adc_ctrl_pkg::*;
  logic [CNT_W-1:0] divider, acq_count;
  logic run, acq_go, tick, acq_active;

  modport ctrl (output divider, acq_count, run, acq_go, input tick, acq_active);

  modport pacer (input divider, acq_count, run, acq_go, output tick, acq_active);
endinterface : pacer_if
`default_nettype wire

// >>> tb/adc_ctrl_properties.sv
// Port assertions for the control block.
// Bound into the control block; one clock domain.
`timescale 1ns/100ps
`default_nettype none
module adc_ctrl_chk
  import adc_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // Register link
  input wire logic REG_REQ,
  input wire logic REG_WRITE,
  input wire logic [31:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_ACK,
  input wire logic [31:0] REG_RDATA,
  // Converter, routing and status
  input wire logic CONV_START,
  input wire logic [4:0] CONV_CH,
  input wire logic [4:0] CONV_NEG,
  input wire logic ACQ_ACTIVE,
  input wire logic RESULT_VALID,
  input wire logic ROUTE_TEMP,
  input wire logic ROUTE_IOVDD_HALF,
  input wire logic ROUTE_AVDD_HALF,
  input wire logic [1:0] INBUF_POWER_OFF,
  input wire logic [1:0] INBUF_SKIP,
  input wire logic CMP_TRIP
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  // Marks an access in flight so a held request counts once.
  logic pend_reg;
  logic clr_req;
  assign clr_req = REG_REQ && REG_WRITE && REG_WDATA[CMP_FLAG_BIT] &&
    REG_ADDR == OFS_DIGITAL_THRESHOLD_CONFIG;
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) pend_reg <= 1'b0;
    else pend_reg <= !REG_ACK && (pend_reg || REG_REQ);
  end
  property p_ack_lat;
    REG_REQ && !pend_reg |=> ##1 REG_ACK ##1 !REG_ACK;
  endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("late ack");
  property p_wr_rdata;
    REG_ACK && $past(REG_WRITE) |-> REG_RDATA == 32'h0;
  endproperty
  a_wr_rdata: assert property (p_wr_rdata) else $error("write data");
  property p_ctl_rd;
    REG_ACK && $past(!REG_WRITE && REG_ADDR == OFS_SEQUENCER_CONTROL) |-> REG_RDATA[31:29] == 3'h0;
  endproperty
  a_ctl_rd: assert property (p_ctl_rd) else $error("strobe read");
  property p_acq;
    CONV_START |=> ACQ_ACTIVE;
  endproperty
  a_acq: assert property (p_acq) else $error("no acq");
  property p_neg;
    CONV_START |=> (CONV_CH inside {5'h00, 5'h02, 5'h04, 5'h06}) || CONV_NEG == NEG_SINGLE_ENDED;
  endproperty
  a_neg: assert property (p_neg) else $error("neg input");
  property p_route;
    CONV_START |=> ##1 {ROUTE_AVDD_HALF, ROUTE_IOVDD_HALF, ROUTE_TEMP} ==
      {CONV_CH == CH_AVDD_HALF, CONV_CH == CH_IOVDD_HALF, CONV_CH == CH_TEMP_SENSOR};
  endproperty
  a_route: assert property (p_route) else $error("route");
  property p_trip_set;
    $rose(CMP_TRIP) |-> ($past(RESULT_VALID) || $past(RESULT_VALID, 2)) && CONV_CH == CMP_CHANNEL;
  endproperty
  a_trip_set: assert property (p_trip_set) else $error("trip source");
  property p_trip_clr;
    $fell(CMP_TRIP) |-> $past(clr_req) || $past(clr_req, 2);
  endproperty
  a_trip_clr: assert property (p_trip_clr) else $error("flag lost");
  property p_ibuf;
    REG_ACK && $past(REG_WRITE && REG_ADDR == OFS_INPUT_BUFFER_CONTROL) |=>
      {INBUF_POWER_OFF, INBUF_SKIP} == $past(REG_WDATA[3:0], 2);
  endproperty
  a_ibuf: assert property (p_ibuf) else $error("ibuf stale");
  c_trip: cover property ($rose(CMP_TRIP));
  c_route: cover property (CONV_START ##2 ROUTE_TEMP);
  c_start: cover property (CONV_START ##[1:20] CONV_START);
endmodule : adc_ctrl_chk
bind adc_sequencer_control adc_ctrl_chk u_chk (.*);
`default_nettype wire

// >>> tb/adc_sequencer_control_tb.sv
// Bench for the converter control block.
// Inputs change on the falling edge; a model answers conversions.
`timescale 1ns/100ps
`default_nettype none
module adc_sequencer_control_tb;
  import adc_ctrl_pkg::*;
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e); end end
  logic CLK_SYS, RST_N, REG_ACK, CONV_START, ACQ_ACTIVE, RESULT_VALID, ROUTE_TEMP;
  logic ROUTE_IOVDD_HALF, ROUTE_AVDD_HALF, TEMP_POWER_OFF, TEMP_MODULATION, SEQ_BUSY, CMP_TRIP;
  logic REG_REQ = 1'b0, REG_WRITE = 1'b0, SINGLE_REQ = 1'b0;
  logic [4:0] SINGLE_CH = 5'h00;
  logic [31:0] REG_ADDR = 32'h0, REG_WDATA = 32'h0;
  logic [15:0] ch4_data = 16'h2000;
  logic [31:0] REG_RDATA;
  logic [4:0] CONV_CH, CONV_NEG;
  logic [15:0] RESULT_DATA;
  logic [1:0] INBUF_POWER_OFF, INBUF_SKIP;
  logic [3:0] REF_CTRL;
  int num_errors = 0, samples_checked = 0;
  localparam logic [4:0] EC[5] = '{5'h00, 5'h01, 5'h04, 5'h05, 5'h00};
  localparam logic [4:0] NG[5] = '{5'h03, 5'h11, 5'h07, 5'h11, 5'h03};
  localparam logic [4:0] SC[3] = '{CH_TEMP_SENSOR, CH_IOVDD_HALF, CH_AVDD_HALF};
  // Keeps 500 ns acquisition; divider 16 gives 8 cycles.
  localparam logic [31:0] TIM = 32'h000A0010;
  adc_sequencer_control u_dut (.*);
  conv_model u_conv (.*);
  task automatic results();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  task automatic timeout();
    num_errors++;
    $display("ERROR t=%0t timeout", $time);
    results();
  endtask : timeout
  task automatic do_reset();
    RST_N = 1'b0;
    repeat (16) @(negedge CLK_SYS);
    RST_N = 1'b1;
  endtask : do_reset
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    @(negedge CLK_SYS);
    REG_REQ = 1'b1;
    REG_WRITE = w;
    REG_ADDR = a;
    REG_WDATA = d;
    n = 0;
    do begin
      @(posedge CLK_SYS);
      n++;
    end while (REG_ACK !== 1'b1 && n < 20);
    if (REG_ACK !== 1'b1) timeout();
    q = REG_RDATA;
    @(negedge CLK_SYS);
    REG_REQ = 1'b0;
  endtask : xfer
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rc(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    `CHK(q, e)
  endtask : rc
  task automatic wst(output logic [4:0] ch, output logic [4:0] ng, output int gap);
    gap = 0;
    do begin
      @(posedge CLK_SYS);
      gap++;
    end while (CONV_START !== 1'b1 && gap < 200);
    if (CONV_START !== 1'b1) timeout();
    @(negedge CLK_SYS);
    ch = CONV_CH;
    ng = CONV_NEG;
  endtask : wst
  task automatic seq_go(input logic [31:0] cfg, input logic [31:0] mask);
    do_reset();
    wr(OFS_CONVERSION_TIMING_CONFIG, TIM);
    wr(OFS_SEQUENCER_CONFIGURATION, cfg);
    wr(OFS_SEQUENCER_CONTROL, mask);
    wr(OFS_SEQUENCER_CONTROL, mask | 32'h40000000);
  endtask : seq_go
  task automatic t_regs();
    do_reset();
    `CHK({INBUF_POWER_OFF, INBUF_SKIP, CONV_NEG}, 9'h1F1)
    rc(OFS_SEQUENCER_CONTROL, 32'h0);
    rc(OFS_SEQUENCER_CONFIGURATION, 32'h0008C631);
    rc(OFS_CONVERSION_TIMING_CONFIG, 32'h000A00C8);
    rc(OFS_INPUT_BUFFER_CONTROL, 32'h0000000F);
    rc(OFS_DIGITAL_THRESHOLD_CONFIG, 32'h0);
    rc(OFS_TEMPERATURE_SENSOR_CONFIG, 32'h0);
    wr(OFS_INPUT_BUFFER_CONTROL, 32'h00000006);
    wr(OFS_TEMPERATURE_SENSOR_CONFIG, 32'h000000FD);
    wr(OFS_REFERENCE_CONFIG, 32'h0000000F);
    wr(32'h40086090, 32'hFFFFFFFF);
    rc(32'h40086090, 32'h0);
    rc(OFS_TEMPERATURE_SENSOR_CONFIG, 32'h00000001);
    `CHK({INBUF_POWER_OFF, INBUF_SKIP}, 4'h6)
    `CHK({TEMP_MODULATION, TEMP_POWER_OFF, REF_CTRL}, 6'h1F)
    $display("t_regs done");
  endtask : t_regs
  task automatic t_seq();
    logic [4:0] ch, ng;
    int gap, n;
    seq_go(32'h00089E23, 32'h00000033);
    for (int i = 0; i < 5; i++) begin
      wst(ch, ng, gap);
      `CHK({ch, ng}, {EC[i], NG[i]})
      if (i > 0) `CHK(gap, 8)
    end
    n = 0;
    while (ACQ_ACTIVE === 1'b1 && n < 50) begin
      @(negedge CLK_SYS);
      n++;
    end
    `CHK(n, 5)
    $display("t_seq done");
  endtask : t_seq
  task automatic t_delay();
    logic [4:0] ch, ng;
    int gap;
    seq_go(32'h0028C631, 32'h00000005);
    wst(ch, ng, gap);
    wst(ch, ng, gap);
    `CHK(gap, 8)
    wst(ch, ng, gap);
    `CHK({ch, gap}, {5'h00, 32'd24})
    wr(OFS_SEQUENCER_CONTROL, 32'h80000005);
    wst(ch, ng, gap);
    `CHK(ch, 5'h00)
    $display("t_delay done");
  endtask : t_delay
  task automatic t_halt();
    logic [4:0] ch, ng;
    int gap, n;
    seq_go(32'h0FF8C631, 32'h00000003);
    wst(ch, ng, gap);
    wst(ch, ng, gap);
    `CHK(ch, 5'h01)
    n = 0;
    repeat (40) begin
      @(posedge CLK_SYS);
      if (CONV_START === 1'b1) n++;
    end
    `CHK({n, SEQ_BUSY}, {32'd0, 1'b0})
    wr(OFS_SEQUENCER_CONTROL, 32'h40000003);
    wst(ch, ng, gap);
    `CHK(ch, 5'h00)
    $display("t_halt done");
  endtask : t_halt
  task automatic t_single();
    logic [4:0] ch, ng;
    int gap, n;
    do_reset();
    for (int i = 0; i < 3; i++) begin
      wr(OFS_CONVERSION_TIMING_CONFIG, TIM);
      @(negedge CLK_SYS);
      SINGLE_CH = SC[i];
      SINGLE_REQ = 1'b1;
      @(negedge CLK_SYS);
      SINGLE_REQ = 1'b0;
      rc(OFS_CONVERSION_TIMING_CONFIG, AUTO_TIMING_VALUE);
      wst(ch, ng, gap);
      `CHK({ch, ng}, {SC[i], NEG_SINGLE_ENDED})
      @(negedge CLK_SYS);
      `CHK({ROUTE_AVDD_HALF, ROUTE_IOVDD_HALF, ROUTE_TEMP}, 3'h1 << i)
      n = 0;
      while (SEQ_BUSY !== 1'b0 && n < 400) begin
        @(negedge CLK_SYS);
        n++;
      end
      `CHK(SEQ_BUSY, 1'b0)
    end
    seq_go(32'h0008C631, 32'h00400000);
    wst(ch, ng, gap);
    wst(ch, ng, gap);
    `CHK({ch, gap}, {CH_TEMP_SENSOR, 32'd8})
    rc(OFS_CONVERSION_TIMING_CONFIG, TIM);
    $display("t_single done");
  endtask : t_single
  task automatic t_cmp();
    logic [4:0] ch, ng;
    logic [31:0] q;
    int gap;
    ch4_data = 16'h2000;
    seq_go(32'h0008C631, 32'h00000010);
    wr(OFS_DIGITAL_THRESHOLD_CONFIG, 32'h00004001);
    wst(ch, ng, gap);
    repeat (7) @(negedge CLK_SYS);
    `CHK(CMP_TRIP, 1'b1)
    xfer(1'b0, OFS_DIGITAL_THRESHOLD_CONFIG, 32'h0, q);
    `CHK(q[18], 1'b1)
    wr(OFS_DIGITAL_THRESHOLD_CONFIG, 32'h00044003);
    wst(ch, ng, gap);
    repeat (7) @(negedge CLK_SYS);
    `CHK(CMP_TRIP, 1'b0)
    ch4_data = 16'h0800;
    wst(ch, ng, gap);
    repeat (7) @(negedge CLK_SYS);
    `CHK(CMP_TRIP, 1'b1)
    wr(OFS_DIGITAL_THRESHOLD_CONFIG, 32'h00044002);
    wst(ch, ng, gap);
    repeat (7) @(negedge CLK_SYS);
    `CHK(CMP_TRIP, 1'b0)
    $display("t_cmp done");
  endtask : t_cmp
  initial begin
    CLK_SYS = 1'b0;
    forever #50 CLK_SYS = ~CLK_SYS;
  end
  initial begin
    RST_N = 1'b0;
    t_regs();
    t_seq();
    t_delay();
    t_halt();
    t_single();
    t_cmp();
    results();
  end
endmodule : adc_sequencer_control_tb
`default_nettype wire

// >>> tb/conv_model.sv
// Converter stand-in: one result pulse per started conversion.
// Assumes the conversion period is longer than RES_DLY cycles.
`timescale 1ns/100ps
`default_nettype none
module conv_model #(
  parameter int RES_DLY = 6
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // Converter side of the block
  input wire logic CONV_START,
  input wire logic [4:0] CONV_CH,
  input wire logic [15:0] ch4_data,
  output logic RESULT_VALID,
  output logic [15:0] RESULT_DATA
);
  int cnt;
  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      cnt <= 0;
      RESULT_VALID <= 1'b0;
      RESULT_DATA <= 16'hA5A5;
    end else begin
      RESULT_VALID <= (cnt == 1);
      // Data wanders outside the valid cycle to expose stale reads.
      RESULT_DATA <= (cnt == 1) ? ((CONV_CH == 5'h04) ? ch4_data : {11'h0, CONV_CH}) : ~RESULT_DATA;
      cnt <= CONV_START ? RES_DLY : ((cnt > 0) ? cnt - 1 : 0);
    end
  end
endmodule : conv_model
`default_nettype wire
